// file: pkg/nppc_pkg.sv
// nppc_pkg: constants and types for the nand parameter-page/status host
// assumes an asynchronous 8-bit nand part on the far side of the pins
// Function
// - byte 101 address cycles 22h sizes phases; host only captures it and always sends one address cycle
// - bytes 133-134 max program duration 02bch, host only captures it
// - bytes 135-136 max erase duration 2710h
// - bytes 137-138 max read busy 0019h
// - bytes 139-140 column change wait 60 ns
// - bytes 254-255 hold crc, host verifies
// - crc polynomial 8005h
// - crc seed 4f4eh, no inversion, no reflection
// - status driven each read after 70h
// - status mode holds until next command
package nppc_pkg;
   // ----------------------------------------
   // commands
   // ----------------------------------------
   localparam logic [7:0] CMD_READ_PARAM = 8'hec;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_RESUME = 8'h00;
   localparam logic [7:0] ADDR_PARAM = 8'h00;
   // ----------------------------------------
   // parameter page layout
   // ----------------------------------------
   localparam logic [9:0] PP_LEN = 10'h100;
   localparam logic [9:0] PP_COPIES_LEN = 10'h300;
   localparam logic [7:0] PP_CRC_LO = 8'hfe;
   localparam logic [7:0] PP_CRC_HI = 8'hff;
   localparam logic [7:0] PP_ADDR_CYC = 8'h65;
   localparam logic [7:0] PP_PROG_LO = 8'h85;
   localparam logic [7:0] PP_PROG_HI = 8'h86;
   localparam logic [7:0] PP_ERASE_LO = 8'h87;
   localparam logic [7:0] PP_ERASE_HI = 8'h88;
   localparam logic [7:0] PP_READ_LO = 8'h89;
   localparam logic [7:0] PP_READ_HI = 8'h8a;
   localparam logic [7:0] PP_CCS_LO = 8'h8b;
   localparam logic [7:0] PP_CCS_HI = 8'h8c;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_SEED = 16'h4f4e;
   // ----------------------------------------
   // status bits
   // ----------------------------------------
   localparam int ST_FAIL = 0;
   localparam int ST_FAIL_PREV = 1;
   localparam int ST_ARRAY_RDY = 5;
   localparam int ST_CACHE_RDY = 6;
   localparam int ST_UNPROT = 7;
   // ----------------------------------------
   // bus timing, cycles of 25 ns (all strobe phases)
   // ----------------------------------------
   localparam int CLK_NS = 25;
   localparam int T_PHASE_NS = 25;
   localparam int T_PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WB_NS = 100;
   localparam int T_WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] PH_CYC = 8'(T_PHASE_CYC);
   localparam logic [7:0] WB_CYC = 8'(T_WB_CYC + 1);
   localparam logic [7:0] CCS_MIN_CYC = 8'h04;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic [7:0] dq_o;
      logic dq_oe;
   } nppc_pins_t;
   typedef struct packed {
      logic [7:0] addr_cycles;
      logic [15:0] max_program_duration;
      logic [15:0] max_erase_duration;
      logic [15:0] max_read_busy_duration;
      logic [15:0] column_change_setup_wait;
      logic crc_ok;
   } nppc_params_t;
   typedef struct packed {
      logic fail;
      logic fail_prev;
      logic array_ready;
      logic cache_ready;
      logic unprotected;
   } nppc_status_t;
endpackage

// file: rtl/nppc_crc.sv
// nppc_crc: byte-wide crc16, msb first, no reflection or final xor
// assumes clear and byte strobes never coincide
`timescale 1ns/1ps
module nppc_crc (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic byte_vld,
   input wire logic [7:0] byte_in,
   output logic [15:0] crc
);
   import nppc_pkg::*;
   logic [15:0] next_crc;
   always_comb begin
      next_crc = crc;
      for (int i = 7; i >= 0; i--) begin
         if (next_crc[15] ^ byte_in[i]) begin
            next_crc = {next_crc[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            next_crc = {next_crc[14:0], 1'b0};
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         crc <= CRC_SEED;
      end else if (clear) begin
         crc <= CRC_SEED;
      end else if (byte_vld) begin
         crc <= next_crc;
      end
   end
endmodule // nppc_crc

// file: rtl/nppc_host.sv
// nppc_host: host that reads the nand parameter page and polls status
// assumes nand pins are synchronous to clk_sys, rb_n open drain pulled up
`timescale 1ns/1ps
module nppc_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req_param,
   input wire logic req_status,
   input wire logic req_resume,
   input wire logic [7:0] dq_i,
   input wire logic rb_n,
   output nppc_pkg::nppc_pins_t pins,
   output logic busy,
   output logic done,
   output nppc_pkg::nppc_params_t params,
   output nppc_pkg::nppc_status_t status,
   output logic [7:0] data_out,
   output logic data_vld,
   output logic copy_mismatch
);
   import nppc_pkg::*;
   // ----------------------------------------
   // state machine
   // ----------------------------------------
   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_CMD = 9'h002,
      S_ADDR = 9'h004,
      S_WB = 9'h008,
      S_WAIT_RB = 9'h010,
      S_RD_LO = 9'h020,
      S_RD_HI = 9'h040,
      S_STAT = 9'h080,
      S_GAP = 9'h100
   } nppc_state_t;
   nppc_state_t state, next_state;
   logic [7:0] tmr;
   logic [9:0] idx;
   logic [7:0] cmd, next_cmd;
   logic stat_mode;
   logic page_open;
   logic [7:0] page_mem [256];
   logic [15:0] crc;
   logic [7:0] crc_lo;
   logic [7:0] mem_q;
   wire tmr_zero = (tmr == 8'h00);
   wire [7:0] bidx = idx[7:0];
   wire in_first = (idx < PP_LEN);
   wire last_byte = (idx == PP_COPIES_LEN - 10'h001);
   wire crc_feed = in_first && (bidx < PP_CRC_LO) && (state == S_RD_HI)
                   && tmr_zero;
   wire crc_clear = (state == S_CMD) && (cmd == CMD_READ_PARAM);
   wire take_byte = (state == S_RD_HI) && tmr_zero;
   // ----------------------------------------
   // request decode
   // ----------------------------------------
   // a resume only makes sense while a page read is still open
   wire resume_ok = req_resume && stat_mode && page_open;
   wire new_req = req_param || req_status || resume_ok;
   // status poll while the part loads the page: read is paused, not lost
   wire poll_req = (state == S_WAIT_RB) && req_status && !req_param;
   wire take_req = ((state == S_IDLE || state == S_STAT) && new_req)
                   || poll_req;
   always_comb begin
      next_cmd = cmd;
      if (req_param) begin
         next_cmd = CMD_READ_PARAM;
      end else if (req_status) begin
         next_cmd = CMD_READ_STATUS;
      end else begin
         next_cmd = CMD_READ_RESUME;
      end
   end
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (take_req) next_state = S_CMD;
         end
         S_CMD: if (tmr_zero) begin
            if (cmd == CMD_READ_PARAM) next_state = S_ADDR;
            else if (cmd == CMD_READ_STATUS) next_state = S_STAT;
            else next_state = S_GAP;
         end
         S_ADDR: if (tmr_zero) next_state = S_WB;
         S_WB: if (tmr_zero) next_state = S_WAIT_RB;
         S_WAIT_RB: begin
            if (poll_req) begin
               next_state = S_CMD;
            end else if (rb_n) begin
               next_state = S_RD_LO;
            end
         end
         S_RD_LO: if (tmr_zero) next_state = S_RD_HI;
         S_RD_HI: if (tmr_zero) begin
            next_state = last_byte ? S_IDLE : S_RD_LO;
         end
         // re holds low: the part refreshes status by itself
         S_STAT: if (take_req) next_state = S_CMD;
         S_GAP: if (tmr_zero) next_state = S_RD_LO;
         default: next_state = S_IDLE;
      endcase
   end
   // ----------------------------------------
   // sequencing registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         tmr <= 8'h00;
         cmd <= 8'h00;
         stat_mode <= 1'b0;
         page_open <= 1'b0;
         idx <= 10'h000;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            tmr <= (next_state == S_WB) ? WB_CYC :
                   (next_state == S_GAP) ? CCS_MIN_CYC : PH_CYC;
         end else if (!tmr_zero) begin
            tmr <= tmr - 8'h01;
         end
         if (take_req) begin
            cmd <= next_cmd;
            stat_mode <= req_status;
         end
         if (crc_clear) begin
            idx <= 10'h000;
         end else if (take_byte) begin
            idx <= idx + 10'h001;
         end
         // open from the page command until the last copy byte is taken
         if (crc_clear) begin
            page_open <= 1'b1;
         end else if (take_byte && last_byte) begin
            page_open <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // page buffer and crc
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (take_byte && in_first) page_mem[bidx] <= dq_i;
      mem_q <= page_mem[bidx];
   end
   nppc_crc u_crc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clear(crc_clear),
      .byte_vld(crc_feed),
      .byte_in(dq_i),
      .crc(crc)
   );
   // ----------------------------------------
   // pins and results
   // ----------------------------------------
   wire drv_cmd = (state == S_CMD);
   // we drops only in the first cycle of a phase, so every write
   // gets its own rising edge before cle or ale moves on
   wire enter_wr = (next_state == S_CMD || next_state == S_ADDR)
                   && (next_state != state);
   wire next_re_n = !(next_state == S_RD_LO || next_state == S_STAT);
   wire [7:0] next_dq = (next_state == S_ADDR) ? ADDR_PARAM :
                        drv_cmd ? cmd : next_cmd;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                   re_n: 1'b1, dq_o: 8'h00, dq_oe: 1'b0};
         busy <= 1'b0;
         done <= 1'b0;
         params <= '0;
         status <= '0;
         data_out <= 8'h00;
         data_vld <= 1'b0;
         copy_mismatch <= 1'b0;
         crc_lo <= 8'h00;
      end else begin
         pins.ce_n <= (next_state == S_IDLE);
         pins.cle <= (next_state == S_CMD);
         pins.ale <= (next_state == S_ADDR);
         pins.we_n <= !enter_wr;
         pins.re_n <= next_re_n;
         pins.dq_o <= next_dq;
         pins.dq_oe <= (next_state == S_CMD || next_state == S_ADDR);
         busy <= (next_state != S_IDLE) && (next_state != S_STAT);
         done <= take_byte && last_byte;
         data_vld <= take_byte;
         data_out <= dq_i;
         if (take_byte && in_first) begin
            if (bidx == PP_ADDR_CYC) params.addr_cycles <= dq_i;
            if (bidx == PP_PROG_LO) params.max_program_duration[7:0] <= dq_i;
            if (bidx == PP_PROG_HI)
               params.max_program_duration[15:8] <= dq_i;
            if (bidx == PP_ERASE_LO) params.max_erase_duration[7:0] <= dq_i;
            if (bidx == PP_ERASE_HI)
               params.max_erase_duration[15:8] <= dq_i;
            if (bidx == PP_READ_LO)
               params.max_read_busy_duration[7:0] <= dq_i;
            if (bidx == PP_READ_HI)
               params.max_read_busy_duration[15:8] <= dq_i;
            if (bidx == PP_CCS_LO)
               params.column_change_setup_wait[7:0] <= dq_i;
            if (bidx == PP_CCS_HI)
               params.column_change_setup_wait[15:8] <= dq_i;
            if (bidx == PP_CRC_LO) crc_lo <= dq_i;
            if (bidx == PP_CRC_HI)
               params.crc_ok <= ({dq_i, crc_lo} == crc);
         end
         // later copies compared against the stored first copy
         if (crc_clear) copy_mismatch <= 1'b0;
         else if (take_byte && !in_first && mem_q != dq_i)
            copy_mismatch <= 1'b1;
         if (state == S_STAT) begin
            status.fail <= dq_i[ST_FAIL];
            status.fail_prev <= dq_i[ST_FAIL_PREV];
            status.array_ready <= dq_i[ST_ARRAY_RDY];
            status.cache_ready <= dq_i[ST_CACHE_RDY];
            status.unprotected <= dq_i[ST_UNPROT];
         end
      end
   end
endmodule // nppc_host

// file: dv/nppc_chk.sv
// nppc_chk: port assertions for nppc_host
// assumes it is bound onto nppc_host, one clock domain
`timescale 1ns/1ps
module nppc_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req_param,
   input wire logic req_status,
   input wire logic [7:0] dq_i,
   input wire logic rb_n,
   input wire nppc_pkg::nppc_pins_t pins,
   input wire logic busy,
   input wire logic done,
   input wire nppc_pkg::nppc_status_t status,
   input wire logic data_vld,
   input wire logic copy_mismatch
);
   import nppc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_cmd(logic [7:0] c);
      pins.cle && !pins.we_n && pins.dq_oe && pins.dq_o == c;
   endsequence
   // three steady cycles so the registered status has caught up
   sequence s_poll;
      (!busy && !pins.re_n && $stable(dq_i)) [*3];
   endsequence
   property p_param_cmd;
      req_param && !busy |=> s_cmd(CMD_READ_PARAM);
   endproperty
   a_param_cmd: assert property (p_param_cmd) else $error("no ech");
   property p_status_cmd;
      req_status && !req_param && !busy |=> s_cmd(CMD_READ_STATUS);
   endproperty
   a_status_cmd: assert property (p_status_cmd) else $error("no 70h");
   property p_phase;
      !pins.we_n |-> pins.dq_oe && (pins.cle != pins.ale);
   endproperty
   a_phase: assert property (p_phase) else $error("bad write cycle");
   property p_byte;
      $fell(pins.re_n) && busy |=> !pins.re_n ##1 pins.re_n ##1 pins.re_n;
   endproperty
   a_byte: assert property (p_byte) else $error("bad read cycle");
   property p_wait_rb;
      busy && !rb_n |-> pins.re_n;
   endproperty
   a_wait_rb: assert property (p_wait_rb) else $error("read while busy");
   property p_vld;
      data_vld |=> !data_vld;
   endproperty
   a_vld: assert property (p_vld) else $error("long data_vld");
   property p_done;
      $rose(done) |=> $fell(done);
   endproperty
   a_done: assert property (p_done) else $error("long done");
   property p_poll;
      s_poll |-> status == {dq_i[0], dq_i[1], dq_i[5], dq_i[6], dq_i[7]};
   endproperty
   a_poll: assert property (p_poll) else $error("stale status");
   property p_sticky;
      copy_mismatch && !(req_param && !busy) && !$past(req_param && !busy)
         |=> copy_mismatch;
   endproperty
   a_sticky: assert property (p_sticky) else $error("lost mismatch");
endmodule // nppc_chk

// file: dv/nppc_nand_model.sv
// nppc_nand_model: behavioural nand part, parameter page and status
// assumes registered host pins on clk_sys; fault picks bad crc or copy
`timescale 1ns/1ps
module nppc_nand_model (
   input wire logic clk_sys,
   input wire nppc_pkg::nppc_pins_t pins,
   input wire logic [7:0] st_val,
   input wire logic [1:0] fault,
   output logic [7:0] dq_i,
   output logic rb_n
);
   import nppc_pkg::*;
   logic [7:0] pg [256];
   logic [7:0] dq_r = 8'h00;
   logic [9:0] idx = 10'h000;
   logic stat_mode = 1'b0;
   logic we_q = 1'b1;
   logic re_q = 1'b1;
   logic [15:0] crc;
   int bsy = 0;
   logic flip;
   initial begin
      for (int i = 0; i < 256; i++) begin
         pg[i] = 8'h00;
      end
      pg[97] = 8'h04;
      {pg[100], pg[101], pg[102]} = {8'h01, 8'h22, 8'h01};
      {pg[103], pg[105], pg[106]} = {8'h14, 8'h01, 8'h05};
      {pg[107], pg[108], pg[109]} = {8'h01, 8'h01, 8'h05};
      {pg[110], pg[112]} = {8'h04, 8'h04};
      {pg[129], pg[131]} = {8'h07, 8'h07};
      {pg[133], pg[134]} = {8'hbc, 8'h02};
      {pg[135], pg[136]} = {8'h10, 8'h27};
      {pg[137], pg[139]} = {8'h19, 8'h3c};
      crc = 16'h4f4e;
      for (int i = 0; i < 254; i++) begin
         for (int b = 7; b >= 0; b--) begin
            crc = {crc[14:0], 1'b0}
                  ^ ({16{crc[15] ^ pg[i][b]}} & 16'h8005);
         end
      end
      {pg[255], pg[254]} = crc;
   end
   assign flip = (fault[0] && idx == 10'h0fe) || (fault[1] && idx == 10'h12c);
   always @(posedge clk_sys) begin
      we_q <= pins.we_n;
      re_q <= pins.re_n;
      if (bsy > 0) bsy <= bsy - 1;
      if (!we_q && pins.we_n && pins.cle) begin
         stat_mode <= (pins.dq_o == CMD_READ_STATUS);
         if (pins.dq_o == CMD_READ_PARAM) idx <= 10'h000;
      end
      if (!we_q && pins.we_n && pins.ale) bsy <= 20;
      if (re_q && !pins.re_n && !stat_mode) begin
         dq_r <= pg[idx[7:0]] ^ {7'h00, flip};
         idx <= idx + 10'h001;
      end
   end
   // deselected: show the inverse, never the held byte
   always_comb begin
      if (pins.ce_n) dq_i = ~dq_r;
      else if (stat_mode) dq_i = st_val;
      else dq_i = dq_r;
   end
   assign rb_n = (bsy == 0);
endmodule // nppc_nand_model

// file: dv/nppc_host_tb_top.sv
// nppc_host_tb_top: directed bench for nppc_host against the nand model
// assumes nppc_pkg, design and dv files compiled before this one
`timescale 1ns/1ps
module nppc_host_tb_top;
   import nppc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic req_param = 1'b0, req_status = 1'b0, req_resume = 1'b0;
   logic [7:0] st_val = 8'h00;
   logic [1:0] fault = 2'b00;
   logic [7:0] dq_i, data_out;
   logic rb_n, busy, done, data_vld, copy_mismatch;
   nppc_pins_t pins;
   nppc_params_t params;
   nppc_status_t status;
   int miscompares = 0;
   int check_count = 0;
   int vcnt = 0;
   always #12.5 clk_sys = ~clk_sys;
   nppc_host nppc_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .req_param(req_param), .req_status(req_status),
      .req_resume(req_resume), .dq_i(dq_i), .rb_n(rb_n), .pins(pins),
      .busy(busy), .done(done), .params(params), .status(status),
      .data_out(data_out), .data_vld(data_vld),
      .copy_mismatch(copy_mismatch));
   nppc_nand_model nppc_nand_model_i (.clk_sys(clk_sys), .pins(pins),
      .st_val(st_val), .fault(fault), .dq_i(dq_i), .rb_n(rb_n));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task pulse(input int k);
      req_param <= (k == 0);
      req_status <= (k == 1);
      req_resume <= (k == 2);
      @(negedge clk_sys);
      {req_param, req_status, req_resume} <= 3'b000;
   endtask
   task wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 5000) begin
         miscompares++;
         end_of_test();
      end
      repeat (2) @(negedge clk_sys);
   endtask
   // ----------------------------------------
   // stream spot checks, every copy
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (data_vld === 1'b1) begin
         case (vcnt % 256)
            97: chk({8'h00, data_out}, 16'h0004);
            101: chk({8'h00, data_out}, 16'h0022);
            103: chk({8'h00, data_out}, 16'h0014);
            112: chk({8'h00, data_out}, 16'h0004);
            default: ;
         endcase
         vcnt <= vcnt + 1;
      end
   end
   task t_refuse;
      pulse(2);
      repeat (5) @(negedge clk_sys);
      chk({15'h0, busy | pins.cle}, 16'h0000);
      $display("test refuse done");
   endtask
   task t_param;
      vcnt = 0;
      pulse(0);
      wait_done();
      chk(16'(vcnt), 16'h0300);
      chk({8'h00, params.addr_cycles}, 16'h0022);
      chk(params.max_program_duration, 16'h02bc);
      chk(params.max_erase_duration, 16'h2710);
      chk(params.max_read_busy_duration, 16'h0019);
      chk(params.column_change_setup_wait, 16'h003c);
      chk({14'h0, params.crc_ok, copy_mismatch}, 16'h0002);
      $display("test param done");
   endtask
   task t_poll;
      int n;
      n = 0;
      vcnt = 0;
      st_val = 8'h00;
      pulse(0);
      repeat (12) @(negedge clk_sys);
      pulse(1);
      repeat (8) @(negedge clk_sys);
      chk({11'h0, status}, 16'h0000);
      chk({15'h0, busy}, 16'h0000);
      while (rb_n !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      chk({15'h0, rb_n}, 16'h0001);
      pulse(2);
      wait_done();
      chk(16'(vcnt), 16'h0300);
      chk({14'h0, params.crc_ok, copy_mismatch}, 16'h0002);
      $display("test poll done");
   endtask
   task t_status;
      st_val = 8'he1;
      pulse(1);
      repeat (20) @(negedge clk_sys);
      chk({11'h0, status}, 16'h0017);
      st_val = 8'h22;
      repeat (6) @(negedge clk_sys);
      chk({11'h0, status}, 16'h000c);
      repeat (200) @(negedge clk_sys);
      st_val = 8'h40;
      repeat (6) @(negedge clk_sys);
      chk({11'h0, status}, 16'h0002);
      pulse(2);
      repeat (4) @(negedge clk_sys);
      chk({15'h0, busy | pins.cle}, 16'h0000);
      $display("test status done");
   endtask
   task t_fault;
      fault = 2'b11;
      pulse(0);
      wait_done();
      chk({14'h0, params.crc_ok, copy_mismatch}, 16'h0001);
      $display("test fault done");
   endtask
   initial begin
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      t_refuse();
      t_param();
      t_poll();
      t_status();
      t_fault();
      end_of_test();
   end
endmodule // nppc_host_tb_top
bind nppc_host nppc_chk nppc_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
   .req_param(req_param), .req_status(req_status), .dq_i(dq_i),
   .rb_n(rb_n), .pins(pins), .busy(busy), .done(done), .status(status),
   .data_vld(data_vld), .copy_mismatch(copy_mismatch));
